// File: design/fsq_pkg.sv
// Shared constants and types of the four-rail power sequencer
package fsq_pkg;

   // Timing clock and documented delays
   localparam int unsigned CLK_KHZ     = 50000;
   localparam int unsigned T_HOLD_MS   = 10;
   localparam int unsigned T_START_MS  = 10;
   localparam int unsigned T_SETTLE_MS = 150;
   localparam int unsigned T_GLITCH_US = 30;
   localparam int unsigned T_RAMP_US   = 1000;

   // Cycle counts derived from the delays
   localparam int unsigned HOLD_CYC   = T_HOLD_MS * CLK_KHZ;
   localparam int unsigned START_CYC  = T_START_MS * CLK_KHZ;
   localparam int unsigned SETTLE_CYC = T_SETTLE_MS * CLK_KHZ;
   localparam int unsigned RAMP_CYC   = (T_RAMP_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned GLITCH_CYC = (T_GLITCH_US * CLK_KHZ + 999) / 1000;

   // Widths
   localparam int unsigned NCH    = 4;
   localparam int unsigned TMR_W  = 23;
   localparam int unsigned GLT_W  = 11;
   localparam int unsigned SYNC_W = 7;

   // Positions in the synchroniser vector
   localparam int unsigned SY_EN1  = 0;
   localparam int unsigned SY_EN2  = 1;
   localparam int unsigned SY_POL  = 2;
   localparam int unsigned SY_OD   = 3;
   localparam int unsigned SY_CASC = 4;
   localparam int unsigned SY_MODE = 5;

   // Operating modes
   localparam logic [1:0] MODE_ALL   = 2'h0;
   localparam logic [1:0] MODE_INDEP = 2'h1;
   localparam logic [1:0] MODE_FIXED = 2'h2;
   localparam logic [1:0] MODE_GROUP = 2'h3;

   // Channel masks (bit 0 is channel A)
   localparam logic [3:0] MASK_ALL  = 4'hf;
   localparam logic [3:0] MASK_AB   = 4'h3;
   localparam logic [3:0] MASK_CD   = 4'hc;
   localparam logic [3:0] MASK_NONE = 4'h0;
   localparam logic [3:0] CH_FIRST  = 4'h1;
   localparam logic [1:0] STEP_A    = 2'h0;
   localparam logic [1:0] STEP_D    = 2'h3;

   typedef enum logic [7:0] {
      S_OFF    = 8'h01,
      S_HOLD   = 8'h02,
      S_ARMED  = 8'h04,
      S_DLY    = 8'h08,
      S_RAMP   = 8'h10,
      S_SETTLE = 8'h20,
      S_ON     = 8'h40,
      S_DOWN   = 8'h80
   } fsq_state_e;

endpackage

// File: design/fsq_uv_if.sv
// Filtered rail status passed from the input filter to the sequencer
`timescale 1ns/10ps
interface fsq_uv_if;
   logic [3:0] rail_ok;
   modport src (output rail_ok);
   modport dst (input rail_ok);
endinterface

// File: design/fsq_uv_filter.sv
// Synchroniser and dip filter for the four rail comparator inputs
`timescale 1ns/10ps
module fsq_uv_filter
   import fsq_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk_i,
   input  wire logic                  rst_b_i,
   // Comparator results, high while the rail is above its level
   input  wire logic [fsq_pkg::NCH-1:0] rail_undervoltage_input_i,
   // Filtered status
   fsq_uv_if.src                      uv
);
   import fsq_pkg::*;

   localparam logic [GLT_W-1:0] GLT_LAST = GLT_W'(GLITCH_CYC - 1);

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++)
      begin : g_ch
         logic             s1_r;
         logic             s2_r;
         logic [GLT_W-1:0] low_cnt_r;
         logic             ok_r;

         always_ff @(posedge mclk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end
            else
            begin
               s1_r <= rail_undervoltage_input_i[ch];
               s2_r <= s1_r;
            end
         end

         // A dip only counts once it has lasted the full window
         always_ff @(posedge mclk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               low_cnt_r <= '0;
               ok_r      <= 1'b0;
            end
            else if (s2_r)
            begin
               low_cnt_r <= '0;
               ok_r      <= 1'b1;
            end
            else if (low_cnt_r == GLT_LAST)
               ok_r <= 1'b0;
            else
               low_cnt_r <= low_cnt_r + 1'b1;
         end

         assign uv.rail_ok[ch] = ok_r;
      end
   endgenerate

endmodule

// File: design/fsq_top.sv
// Control logic of the four-rail power sequencer
// Functional notes
// - Enable starts sequencing: on when asserted, off when withdrawn.
// - Enable is ignored for 10ms after rail levels first become good.
// - Reset output released 150ms after every gate is fully on.
// - Reset output asserts on any rail fault or enable withdrawal.
// - Reset outputs are open-drain and filtered against fast transients.
// - All-rails mode needs all four rails good, before and during operation.
// - Independent mode turns each channel on when its own rail is good.
// - Fixed-order mode: on A-B-C-D, off D-C-B-A.
// - Fixed order starts on all rails good plus enable; one gate at a time.
// - Grouped mode: two groups, all rails to start, faults kept per group.
// - Grouped mode: active-low enable per group, second reset for C, D.
// - Enable polarity selectable: active-high only in standby variant.
// - Active-high variant reports standby when disabled and the sequencer is idle.
// - Open-drain variant drives channels as open-drain logic outputs.
// - Cascaded devices share one open-drain completion wire.
// - Rail dips shorter than 30us are ignored.
// - Turn-on timing begins 10ms after enable starts a turn-on.
`timescale 1ns/10ps
module fsq_top
   import fsq_pkg::*;
#(
   parameter int unsigned HOLD_CYC_P   = fsq_pkg::HOLD_CYC,
   parameter int unsigned START_CYC_P  = fsq_pkg::START_CYC,
   parameter int unsigned SETTLE_CYC_P = fsq_pkg::SETTLE_CYC,
   parameter int unsigned RAMP_CYC_P   = fsq_pkg::RAMP_CYC
)
(
   // Clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    rst_b_i,
   // Rail comparators
   input  wire logic [fsq_pkg::NCH-1:0] rail_undervoltage_input_i,
   // Enables and variant straps
   input  wire logic                    enable1_i,
   input  wire logic                    enable2_n_i,
   input  wire logic                    en_active_high_i,
   input  wire logic                    open_drain_mode_i,
   input  wire logic [1:0]              mode_sel_i,
   // Gate drives and open-drain channel outputs
   output logic      [fsq_pkg::NCH-1:0] gate_on_o,
   output logic      [fsq_pkg::NCH-1:0] chan_od_o,
   output logic      [fsq_pkg::NCH-1:0] chan_od_oe_o,
   // Sequence-complete reset outputs, open-drain
   output logic                         seq_rst1_n_o,
   output logic                         seq_rst1_n_oe_o,
   output logic                         seq_rst2_n_o,
   output logic                         seq_rst2_n_oe_o,
   // Shared cascade wire, open-drain
   input  wire logic                    cascade_done_wire_n_i,
   output logic                         cascade_done_wire_n_o,
   output logic                         cascade_done_wire_n_oe_o,
   // Low-power standby indication
   output logic                         standby_o
);
   import fsq_pkg::*;

   fsq_uv_if uv_bus ();

   fsq_uv_filter u_filter (
      .mclk_i                    (mclk_i),
      .rst_b_i                   (rst_b_i),
      .rail_undervoltage_input_i (rail_undervoltage_input_i),
      .uv                        (uv_bus)
   );

   logic [SYNC_W-1:0] sy1_r;
   logic [SYNC_W-1:0] sy2_r;

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sy1_r <= '0;
         sy2_r <= '0;
      end
      else
      begin
         sy1_r <= {mode_sel_i, cascade_done_wire_n_i, open_drain_mode_i,
                   en_active_high_i, enable2_n_i, enable1_i};
         sy2_r <= sy1_r;
      end
   end

   logic [1:0] mode;
   logic [3:0] ok;
   logic       grouped;
   logic       indep;
   logic       fixed;
   logic       pol_hi;

   assign mode    = sy2_r[SY_MODE +: 2];
   assign ok      = uv_bus.rail_ok;
   assign grouped = (mode == MODE_GROUP);
   assign indep   = (mode == MODE_INDEP);
   assign fixed   = (mode == MODE_FIXED);
   assign pol_hi  = sy2_r[SY_POL] & ~grouped;

   logic [3:0] grp_on   [2];
   logic       grp_done [2];
   logic       grp_idle [2];
   logic       grp_en   [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_grp
         fsq_state_e       st_r;
         fsq_state_e       st_nxt;
         logic [TMR_W-1:0] tmr_r;
         logic [TMR_W-1:0] load_val;
         logic [1:0]       step_r;
         logic [3:0]       on_r;
         logic [3:0]       mask;
         logic             en_act;
         logic             ok_on;
         logic             ok_keep;
         logic             fault;
         logic             zero;
         logic             up_last;
         logic             dn_last;
         logic             full_on;
         logic             step_adv;

         always_comb
         begin
            if (grouped)
               mask = (g == 0) ? MASK_AB : MASK_CD;
            else
               mask = (g == 0) ? MASK_ALL : MASK_NONE;
         end

         // Grouped enables are always active low
         assign en_act = (g == 0) ? (pol_hi ? sy2_r[SY_EN1]
                                             : ~sy2_r[SY_EN1])
                                  : ~sy2_r[SY_EN2];
         assign ok_on   = indep ? |(ok & mask) : &ok;
         assign ok_keep = indep ? 1'b1
                        : grouped ? &(ok | ~mask)
                        : &ok;
         assign fault   = ~ok_keep | ~en_act;
         assign zero    = (tmr_r == '0);
         assign up_last = ~fixed | (step_r == STEP_D);
         assign dn_last = ~fixed | (step_r == STEP_A);
         assign full_on = indep ? &(ok | ~mask) : 1'b1;

         always_comb
         begin
            st_nxt = st_r;
            if (mask == MASK_NONE)
               st_nxt = S_OFF;
            else
               unique case (st_r)
                  S_OFF:
                     if (ok_on)
                        st_nxt = S_HOLD;
                  S_HOLD:
                     if (!ok_keep)
                        st_nxt = S_OFF;
                     else if (zero)
                        st_nxt = S_ARMED;
                  S_ARMED:
                     if (!ok_keep)
                        st_nxt = S_OFF;
                     else if (en_act)
                        st_nxt = S_DLY;
                  S_DLY:
                     if (!ok_keep)
                        st_nxt = S_OFF;
                     else if (!en_act)
                        st_nxt = S_ARMED;
                     else if (zero)
                        st_nxt = S_RAMP;
                  S_RAMP:
                     if (fault)
                        st_nxt = S_DOWN;
                     else if (zero && up_last)
                        st_nxt = S_SETTLE;
                  S_SETTLE:
                     if (fault)
                        st_nxt = S_DOWN;
                     else if (zero && full_on)
                        st_nxt = S_ON;
                  // An independent rail loss reopens the settle wait
                  S_ON:
                     if (fault)
                        st_nxt = S_DOWN;
                     else if (!full_on)
                        st_nxt = S_SETTLE;
                  S_DOWN:
                     if (zero && dn_last)
                        st_nxt = ok_keep ? S_ARMED : S_OFF;
               endcase
         end

         assign step_adv = fixed && zero && (st_nxt == st_r) &&
                           ((st_r == S_RAMP) || (st_r == S_DOWN));

         always_comb
         begin
            unique case (st_nxt)
               S_HOLD:   load_val = TMR_W'(HOLD_CYC_P);
               S_DLY:    load_val = TMR_W'(START_CYC_P);
               S_SETTLE: load_val = TMR_W'(SETTLE_CYC_P);
               S_RAMP,
               S_DOWN:   load_val = TMR_W'(RAMP_CYC_P);
               default:  load_val = '0;
            endcase
         end

         always_ff @(posedge mclk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
               st_r <= S_OFF;
            else
               st_r <= st_nxt;
         end

         always_ff @(posedge mclk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
               tmr_r <= '0;
            // Settle restarts while an independent rail is still down
            else if ((st_nxt != st_r) || step_adv ||
                     ((st_r == S_SETTLE) && !full_on))
               tmr_r <= load_val;
            else if (!zero)
               tmr_r <= tmr_r - 1'b1;
         end

         always_ff @(posedge mclk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
               step_r <= STEP_A;
            else if (st_nxt == S_RAMP && st_r != S_RAMP)
               step_r <= STEP_A;
            else if (st_nxt == S_DOWN && st_r != S_DOWN)
               step_r <= STEP_D;
            else if (step_adv && st_r == S_RAMP)
               step_r <= step_r + 1'b1;
            else if (step_adv)
               step_r <= step_r - 1'b1;
         end

         // Fixed order turns on one channel per ramp period, off in reverse
         always_ff @(posedge mclk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
               on_r <= '0;
            else if (st_r == S_RAMP)
               on_r <= fixed ? (on_r | (mask & (CH_FIRST << step_r)))
                             : mask;
            else if (st_r == S_DOWN)
               on_r <= fixed ? (on_r & ~(CH_FIRST << step_r))
                             : '0;
            else if (st_r != S_SETTLE && st_r != S_ON)
               on_r <= '0;
         end

         assign grp_on[g]   = on_r;
         assign grp_done[g] = (st_r == S_ON);
         assign grp_idle[g] = (st_r == S_OFF) || (st_r == S_HOLD) ||
                              (st_r == S_ARMED);
         assign grp_en[g]   = en_act;
      end
   endgenerate

   logic [3:0] gate_cmb;
   logic       od_mode;
   logic       casc_high;

   // Independent channels follow their own rail status live
   assign gate_cmb  = (grp_on[0] | grp_on[1])
                    & (indep ? ok : MASK_ALL);
   assign od_mode   = sy2_r[SY_OD];
   assign casc_high = sy2_r[SY_CASC];

   // Open-drain data pins only ever pull low; the enables carry the level
   logic od_low_r;

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         od_low_r <= 1'b0;
      else
         od_low_r <= 1'b0;
   end

   assign chan_od_o             = {NCH{od_low_r}};
   assign seq_rst1_n_o          = od_low_r;
   assign seq_rst2_n_o          = od_low_r;
   assign cascade_done_wire_n_o = od_low_r;

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         gate_on_o    <= '0;
         chan_od_oe_o <= MASK_ALL;
      end
      else
      begin
         gate_on_o    <= od_mode ? MASK_NONE : gate_cmb;
         chan_od_oe_o <= od_mode ? ~gate_cmb : MASK_ALL;
      end
   end

   // Reset pins pull low from reset onward, so they read asserted at once
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cascade_done_wire_n_oe_o <= 1'b1;
         seq_rst1_n_oe_o          <= 1'b1;
         seq_rst2_n_oe_o          <= 1'b1;
      end
      else
      begin
         cascade_done_wire_n_oe_o <= ~grp_done[0];
         seq_rst1_n_oe_o <= ~(grp_done[0] & casc_high);
         seq_rst2_n_oe_o <= grouped ? ~grp_done[1]
                                    : ~(grp_done[0] & casc_high);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         standby_o <= 1'b0;
      else
         standby_o <= pol_hi & ~grp_en[0] & grp_idle[0];
   end

endmodule

// File: testbench/fsq_top_monitor.sv
// Pin-level concurrent checks for the sequencer, bound to its top module
`timescale 1ns/10ps
module fsq_top_monitor
   import fsq_pkg::*;
#(
   parameter int unsigned HOLD_CYC_P  = 20,
   parameter int unsigned START_CYC_P = 20
)
(
   // Clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    rst_b_i,
   // Strap
   input  wire logic [1:0]              mode_sel_i,
   // Observed outputs
   input  wire logic [fsq_pkg::NCH-1:0] gate_on_o,
   input  wire logic [fsq_pkg::NCH-1:0] chan_od_o,
   input  wire logic [fsq_pkg::NCH-1:0] chan_od_oe_o,
   input  wire logic                    seq_rst1_n_o,
   input  wire logic                    seq_rst1_n_oe_o,
   input  wire logic                    seq_rst2_n_o,
   input  wire logic                    seq_rst2_n_oe_o,
   input  wire logic                    cascade_done_wire_n_o,
   input  wire logic                    cascade_done_wire_n_oe_o,
   input  wire logic                    standby_o
);
   logic [3:0]  on_w;
   logic [31:0] cyc_r;

   // A channel counts as on whether driven as a gate or released open-drain
   assign on_w = gate_on_o | ~chan_od_oe_o;

   // Stops at the end of the start window, so full-length delays never wrap
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         cyc_r <= 32'h0;
      else if (cyc_r < HOLD_CYC_P + START_CYC_P)
         cyc_r <= cyc_r + 32'h1;
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_done;
      $fell(seq_rst1_n_oe_o);
   endsequence

   chk_od_data_low: assert property (
      (chan_od_o == 4'h0) && !seq_rst1_n_o
      && !seq_rst2_n_o && !cascade_done_wire_n_o)
      else $error("open-drain data driven high");
   chk_settle_done: assert property (s_done |-> (&on_w[1:0])
      && $past(&on_w[1:0], 40))
      else $error("reset released before gates settled");
   chk_cascade_first: assert property (
      s_done |-> !cascade_done_wire_n_oe_o)
      else $error("reset released while cascade wire held");
   chk_group2_done: assert property (
      $fell(seq_rst2_n_oe_o) |-> &on_w[3:2])
      else $error("second reset released with C or D off");
   chk_fault_reset: assert property (
      $fell(on_w[0]) |-> ##[0:2] seq_rst1_n_oe_o)
      else $error("gate off without reset asserted");
   chk_od_exclusive: assert property ((gate_on_o != 4'h0)
      |-> (chan_od_oe_o == 4'hf))
      else $error("gate drive and open-drain output both active");
   chk_fixed_order: assert property ((mode_sel_i == MODE_FIXED)
      |-> (on_w inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}))
      else $error("fixed order gate pattern broken");
   chk_fixed_step: assert property ((mode_sel_i == MODE_FIXED)
      && $rose(on_w[1]) |-> $past(on_w[0], 5))
      else $error("gate B started before A finished");
   chk_standby_off: assert property (standby_o |-> (on_w == 4'h0)
      && seq_rst1_n_oe_o)
      else $error("standby with a channel on");
   chk_start_delay: assert property (
      (cyc_r < HOLD_CYC_P + START_CYC_P) |-> (on_w == 4'h0))
      else $error("gate on inside hold and start delay");
endmodule

bind fsq_top fsq_top_monitor #(
   .HOLD_CYC_P  (HOLD_CYC_P),
   .START_CYC_P (START_CYC_P)
) i_mon (
   .mclk_i                   (mclk_i),
   .rst_b_i                  (rst_b_i),
   .mode_sel_i               (mode_sel_i),
   .gate_on_o                (gate_on_o),
   .chan_od_o                (chan_od_o),
   .chan_od_oe_o             (chan_od_oe_o),
   .seq_rst1_n_o             (seq_rst1_n_o),
   .seq_rst1_n_oe_o          (seq_rst1_n_oe_o),
   .seq_rst2_n_o             (seq_rst2_n_o),
   .seq_rst2_n_oe_o          (seq_rst2_n_oe_o),
   .cascade_done_wire_n_o    (cascade_done_wire_n_o),
   .cascade_done_wire_n_oe_o (cascade_done_wire_n_oe_o),
   .standby_o                (standby_o)
);

// File: testbench/fsq_supply_model.sv
// Rails, comparators and the cascaded peer on the shared completion wire
`timescale 1ns/10ps
module fsq_supply_model
(
   // Bench commands
   input  wire logic [3:0] rail_cmd_i,
   input  wire logic       peer_hold_i,
   // Device side
   input  wire logic       done_oe_i,
   output logic      [3:0] rail_good_o,
   output logic            wire_level_o
);
   // Comparator result follows the commanded rail level
   assign rail_good_o  = rail_cmd_i;
   // Pulled up; any party not yet done holds it low
   assign wire_level_o = !(done_oe_i || peer_hold_i);
endmodule

// File: testbench/tb_four_rail_power_sequencer.sv
// Self-checking bench for the four-rail power sequencer
`timescale 1ns/10ps
module tb_four_rail_power_sequencer;
   import fsq_pkg::*;
   logic       mclk;
   logic       rst_b;
   logic [3:0] rail_cmd;
   logic [3:0] rails;
   logic [3:0] gate_on;
   logic [3:0] od_oe;
   logic [3:0] on_w;
   logic       en1;
   logic       en2_n;
   logic       ah;
   logic       odm;
   logic       peer;
   logic [1:0] mode;
   logic       r1_oe;
   logic       r2_oe;
   logic       cw;
   logic       cw_oe;
   logic       stby;
   int         mismatches;
   int         num_checks;

   assign on_w = gate_on | ~od_oe;

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   fsq_top #(.HOLD_CYC_P(20), .START_CYC_P(20), .SETTLE_CYC_P(50),
      .RAMP_CYC_P(10)) i_dut (
      .mclk_i(mclk), .rst_b_i(rst_b), .rail_undervoltage_input_i(rails),
      .enable1_i(en1), .enable2_n_i(en2_n), .en_active_high_i(ah),
      .open_drain_mode_i(odm), .mode_sel_i(mode), .gate_on_o(gate_on),
      .chan_od_o(), .chan_od_oe_o(od_oe), .seq_rst1_n_o(),
      .seq_rst1_n_oe_o(r1_oe), .seq_rst2_n_o(), .seq_rst2_n_oe_o(r2_oe),
      .cascade_done_wire_n_i(cw), .cascade_done_wire_n_o(),
      .cascade_done_wire_n_oe_o(cw_oe), .standby_o(stby));

   fsq_supply_model i_sup (.rail_cmd_i(rail_cmd), .peer_hold_i(peer),
      .done_oe_i(cw_oe), .rail_good_o(rails), .wire_level_o(cw));

   task automatic check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         mismatches++;
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wait_on(input logic [3:0] exp, input int max);
      int n;
      n = 0;
      while (on_w !== exp && n < max)
      begin
         idle(1);
         n++;
      end
      check("gates", 8'(on_w), 8'(exp));
   endtask

   task automatic wait_rst(input logic exp, input int max, output int n);
      n = 0;
      while (r1_oe !== exp && n < max)
      begin
         idle(1);
         n++;
      end
      check("rst1_oe", 8'(r1_oe), 8'(exp));
   endtask

   // Straps change only under reset so each test starts clean
   task automatic start(input logic [1:0] m, input logic a, input logic o,
      input logic e1);
      @(posedge mclk);
      rst_b <= 1'b0;
      mode <= m;
      ah <= a;
      odm <= o;
      en1 <= e1;
      en2_n <= 1'b0;
      peer <= 1'b0;
      rail_cmd <= 4'hf;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
   endtask

   task automatic test_all_rails;
      int n;
      start(MODE_ALL, 1'b0, 1'b0, 1'b0);
      @(posedge mclk);
      peer <= 1'b1;
      idle(30);
      check("gates_early", 8'(on_w), 8'h00);
      wait_on(4'hf, 100);
      idle(100);
      check("rst1_oe", 8'(r1_oe), 8'h01);
      check("casc_oe", 8'(cw_oe), 8'h00);
      @(posedge mclk);
      peer <= 1'b0;
      wait_rst(1'b0, 10, n);
      @(posedge mclk);
      rail_cmd <= 4'he;
      idle(500);
      @(posedge mclk);
      rail_cmd <= 4'hf;
      idle(10);
      check("dip_rst", 8'(r1_oe), 8'h00);
      check("dip_gates", 8'(on_w), 8'h0f);
      @(posedge mclk);
      rail_cmd <= 4'he;
      wait_rst(1'b1, 1600, n);
      check("fault_delay", 8'(n >= 1400), 8'h01);
      wait_on(4'h0, 20);
      $display("test all_rails done");
   endtask

   task automatic test_fixed_order;
      int n;
      start(MODE_FIXED, 1'b0, 1'b0, 1'b0);
      wait_on(4'h1, 100);
      wait_on(4'h3, 30);
      wait_on(4'h7, 30);
      wait_on(4'hf, 30);
      wait_rst(1'b0, 100, n);
      @(posedge mclk);
      en1 <= 1'b1;
      wait_on(4'h7, 20);
      wait_rst(1'b1, 5, n);
      wait_on(4'h3, 30);
      wait_on(4'h1, 30);
      wait_on(4'h0, 30);
      $display("test fixed_order done");
   endtask

   task automatic test_grouped;
      int n;
      start(MODE_GROUP, 1'b0, 1'b0, 1'b0);
      wait_on(4'hf, 100);
      wait_rst(1'b0, 100, n);
      check("rst2_oe", 8'(r2_oe), 8'h00);
      @(posedge mclk);
      en2_n <= 1'b1;
      wait_on(4'h3, 10);
      check("rst2_off", 8'(r2_oe), 8'h01);
      check("rst1_kept", 8'(r1_oe), 8'h00);
      @(posedge mclk);
      en2_n <= 1'b0;
      wait_on(4'hf, 100);
      idle(70);
      check("rst2_again", 8'(r2_oe), 8'h00);
      @(posedge mclk);
      rail_cmd <= 4'hb;
      wait_on(4'h3, 1600);
      idle(3);
      check("rst2_oe", 8'(r2_oe), 8'h01);
      check("rst1_oe", 8'(r1_oe), 8'h00);
      $display("test grouped done");
   endtask

   task automatic test_standby_od;
      start(MODE_ALL, 1'b1, 1'b1, 1'b0);
      idle(60);
      check("standby", 8'(stby), 8'h01);
      check("gates_off", 8'(on_w), 8'h00);
      @(posedge mclk);
      en1 <= 1'b1;
      wait_on(4'hf, 100);
      check("gate_drive", 8'(gate_on), 8'h00);
      check("standby", 8'(stby), 8'h00);
      $display("test standby_od done");
   endtask

   task automatic test_independent;
      int n;
      start(MODE_INDEP, 1'b0, 1'b0, 1'b0);
      wait_on(4'hf, 100);
      wait_rst(1'b0, 100, n);
      @(posedge mclk);
      rail_cmd <= 4'hd;
      wait_on(4'hd, 1600);
      wait_rst(1'b1, 3, n);
      @(posedge mclk);
      rail_cmd <= 4'hf;
      wait_on(4'hf, 10);
      wait_rst(1'b0, 100, n);
      check("resettle", 8'(n >= 45), 8'h01);
      $display("test independent done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Whole run needs well under ten thousand cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      end_of_test();
   end

   initial
   begin
      rst_b = 1'b0;
      rail_cmd = 4'hf;
      en1 = 1'b1;
      en2_n = 1'b1;
      ah = 1'b0;
      odm = 1'b0;
      peer = 1'b0;
      mode = MODE_ALL;
      mismatches = 0;
      num_checks = 0;
      test_all_rails();
      test_fixed_order();
      test_grouped();
      test_standby_od();
      test_independent();
      end_of_test();
   end
endmodule
